// *** include/ecr_pkg.sv ***
// Shared constants and carriers for the extended sequencer register bank
package ecr_pkg;

   // Host port request, one cycle wide
   typedef struct packed {
      logic       write;
      logic       read;
      logic       data_port;
      logic       mmio;
      logic [7:0] wdata;
   } ecr_io_req_s;

   // One clock synthesizer divider set
   typedef struct packed {
      logic [6:0] m;
      logic [1:0] r;
      logic [4:0] n;
   } ecr_synth_s;

   // Bank indices
   localparam logic [7:0] ECR_IDX_UNLOCK     = 8'h08;
   localparam logic [7:0] ECR_IDX_ACCESS     = 8'h09;
   localparam logic [7:0] ECR_IDX_MEMBUS     = 8'h0a;
   localparam logic [7:0] ECR_IDX_VIDCLK     = 8'h0b;
   localparam logic [7:0] ECR_IDX_CONNSYNC   = 8'h0d;
   localparam logic [7:0] ECR_IDX_MCLK_LOW   = 8'h10;
   localparam logic [7:0] ECR_IDX_MCLK_HIGH  = 8'h11;
   localparam logic [7:0] ECR_IDX_DOT_CLOCK_LOW   = 8'h12;
   localparam logic [7:0] ECR_IDX_DOT_CLOCK_HIGH  = 8'h13;
   localparam logic [7:0] ECR_IDX_SYNTH_LOAD = 8'h15;
   localparam logic [7:0] ECR_IDX_LOCK_FIRST = 8'h09;
   localparam logic [7:0] ECR_IDX_LOCK_LAST  = 8'h1c;

   // Unlock key sits in the low nibble only
   localparam logic [3:0] ECR_UNLOCK_KEY     = 4'h6;
   localparam int         ECR_UNLOCK_MSB     = 3;

   // Field positions
   localparam int ECR_BIT_MMIO_ONLY   = 7;
   localparam int ECR_BIT_PIX_DRIVE   = 5;
   localparam int ECR_BIT_SECOND_RAS  = 6;
   localparam int ECR_BIT_TWO_MCLK_WR = 7;
   localparam int ECR_BIT_DOT_EXT     = 0;
   localparam int ECR_BIT_CAPT_EXT    = 1;
   localparam int ECR_COLOR_MSB       = 7;
   localparam int ECR_COLOR_LSB       = 4;
   localparam int ECR_BIT_FC_ENABLE   = 0;
   localparam int ECR_BIT_FC_LOCAL    = 1;
   localparam int ECR_HSYNC_MSB       = 5;
   localparam int ECR_HSYNC_LSB       = 4;
   localparam int ECR_VSYNC_MSB       = 7;
   localparam int ECR_VSYNC_LSB       = 6;
   localparam int ECR_N_MSB           = 4;
   localparam int ECR_N_LSB           = 0;
   localparam int ECR_R_MSB           = 6;
   localparam int ECR_R_LSB           = 5;
   localparam int ECR_M_MSB           = 6;
   localparam int ECR_M_LSB           = 0;
   localparam int ECR_BIT_LOAD_MCLK   = 0;
   localparam int ECR_BIT_LOAD_DOT_CLOCK   = 1;
   localparam int ECR_BIT_LOAD_NOW    = 5;

   // Reset values
   localparam logic [7:0] ECR_RESET_BYTE  = 8'h00;
   localparam ecr_synth_s ECR_RESET_SYNTH = '0;

endpackage

// *** design/ecr_synth_latch.sv ***
`timescale 1ns/1ps
`default_nettype none

// Active divider set for one synthesizer; follows programmed values on load
module ecr_synth_latch
   import ecr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire ecr_synth_s programmed,
   input  wire logic       load,
   output var  ecr_synth_s active
);

   ecr_synth_s next_active;

   // New dividers only reach the synthesizer on a load; with the load-now bit set every divider byte write is a load
   always_comb begin
      next_active = active;
      if (load) begin
         next_active = programmed;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         active <= ECR_RESET_SYNTH;
      end else begin
         active <= next_active;
      end
   end

endmodule

`default_nettype wire

// *** design/ecr_regs.sv ***
// Notes on behaviour
// - Bank writes at indices 09h-1Ch need unlock low nibble 0110b
// - MMIO-only bit makes port I/O ignored
// - Drive-enable bit keeps pixel bus driven
// - Two-clock memory write select bit
// - External video clock drives dot functions
// - Feature pixels captured on external clock
// - Feature input colour-mode code field
// - Feature connector enable and local-bus select
// - Horizontal and vertical sync power controls
// - Memory clock N, R, M dividers
// - Dot clock N, R, M dividers
// - Dividers apply on load bit or immediately
`timescale 1ns/1ps
`default_nettype none

module ecr_regs
   import ecr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire ecr_io_req_s io_req,
   output logic [7:0]       io_rdata,
   output logic             io_rvalid,
   output logic             bank_unlocked,
   output logic             mmio_only,
   output logic             pixel_bus_drive,
   output logic             second_row_strobe_en,
   output logic             mem_write_two_clocks,
   output logic             dot_clock_from_ext,
   output logic             capture_on_ext_clock,
   output logic [3:0]       feature_color_mode,
   output logic             feature_enable,
   output logic             local_peripheral_bus_sel,
   output logic [1:0]       hsync_control,
   output logic [1:0]       vsync_control,
   output ecr_synth_s       memclk_active,
   output ecr_synth_s       dotclk_active
);

   // Stored bytes
   logic [7:0] index;
   logic [7:0] bank_unlock;
   logic [7:0] access_mode_select;
   logic [7:0] memory_bus_options;
   logic [7:0] video_input_clocking;
   logic [7:0] connector_and_sync_control;
   logic [7:0] memclk_divider_low;
   logic [7:0] memclk_divider_high;
   logic [7:0] dotclk_divider_low;
   logic [7:0] dotclk_divider_high;
   logic [7:0] synth_load_control;
   logic       load_mem;
   logic       load_dot;
   logic       unlocked_q;

   logic [7:0] next_index;
   logic [7:0] next_bank_unlock;
   logic [7:0] next_access_mode_select;
   logic [7:0] next_memory_bus_options;
   logic [7:0] next_video_input_clocking;
   logic [7:0] next_connector_and_sync_control;
   logic [7:0] next_memclk_divider_low;
   logic [7:0] next_memclk_divider_high;
   logic [7:0] next_dotclk_divider_low;
   logic [7:0] next_dotclk_divider_high;
   logic [7:0] next_synth_load_control;
   logic [7:0] next_io_rdata;
   logic       next_io_rvalid;
   logic       next_load_mem;
   logic       next_load_dot;
   logic       next_unlocked_q;

   logic       access_ok;
   logic       key_ok;
   logic       in_locked_range;
   logic       data_write;
   logic       bank_write_ok;
   logic       load_now;
   logic [7:0] read_byte;
   ecr_synth_s memclk_programmed;
   ecr_synth_s dotclk_programmed;

   // Port I/O is shut out once the MMIO-only bit is set
   assign access_ok = io_req.mmio
                    | ~access_mode_select[ECR_BIT_MMIO_ONLY];

   // Only the low nibble of the unlock byte is compared
   assign key_ok = (bank_unlock[ECR_UNLOCK_MSB:0] == ECR_UNLOCK_KEY);
   assign in_locked_range = (index >= ECR_IDX_LOCK_FIRST)
                          & (index <= ECR_IDX_LOCK_LAST);
   assign data_write = access_ok & io_req.write & io_req.data_port;
   assign bank_write_ok = data_write & (~in_locked_range | key_ok);
   assign load_now = synth_load_control[ECR_BIT_LOAD_NOW];

   // Divider fields as the synthesizers see them
   assign memclk_programmed.n =
      memclk_divider_low[ECR_N_MSB:ECR_N_LSB];
   assign memclk_programmed.r =
      memclk_divider_low[ECR_R_MSB:ECR_R_LSB];
   assign memclk_programmed.m =
      memclk_divider_high[ECR_M_MSB:ECR_M_LSB];
   assign dotclk_programmed.n =
      dotclk_divider_low[ECR_N_MSB:ECR_N_LSB];
   assign dotclk_programmed.r =
      dotclk_divider_low[ECR_R_MSB:ECR_R_LSB];
   assign dotclk_programmed.m =
      dotclk_divider_high[ECR_M_MSB:ECR_M_LSB];

   // Read multiplexer; unmapped indices read as zero
   always_comb begin
      case (index)
         ECR_IDX_UNLOCK:     read_byte = bank_unlock;
         ECR_IDX_ACCESS:     read_byte = access_mode_select;
         ECR_IDX_MEMBUS:     read_byte = memory_bus_options;
         ECR_IDX_VIDCLK:     read_byte = video_input_clocking;
         ECR_IDX_CONNSYNC:   read_byte = connector_and_sync_control;
         ECR_IDX_MCLK_LOW:   read_byte = memclk_divider_low;
         ECR_IDX_MCLK_HIGH:  read_byte = memclk_divider_high;
         ECR_IDX_DOT_CLOCK_LOW:   read_byte = dotclk_divider_low;
         ECR_IDX_DOT_CLOCK_HIGH:  read_byte = dotclk_divider_high;
         ECR_IDX_SYNTH_LOAD: read_byte = synth_load_control;
         default:            read_byte = ECR_RESET_BYTE;
      endcase
   end

   // Next values for the register file and the load strobes
   always_comb begin
      next_index                      = index;
      next_bank_unlock                = bank_unlock;
      next_access_mode_select         = access_mode_select;
      next_memory_bus_options         = memory_bus_options;
      next_video_input_clocking       = video_input_clocking;
      next_connector_and_sync_control = connector_and_sync_control;
      next_memclk_divider_low         = memclk_divider_low;
      next_memclk_divider_high        = memclk_divider_high;
      next_dotclk_divider_low         = dotclk_divider_low;
      next_dotclk_divider_high        = dotclk_divider_high;
      next_synth_load_control         = synth_load_control;
      next_load_mem                   = 1'b0;
      next_load_dot                   = 1'b0;
      // Index port write selects the register for the data port
      if (access_ok && io_req.write && !io_req.data_port) begin
         next_index = io_req.wdata;
      end
      // Whole bytes are stored, reserved bits included
      if (bank_write_ok) begin
         case (index)
            ECR_IDX_UNLOCK:     next_bank_unlock = io_req.wdata;
            ECR_IDX_ACCESS:     next_access_mode_select = io_req.wdata;
            ECR_IDX_MEMBUS:     next_memory_bus_options = io_req.wdata;
            ECR_IDX_VIDCLK:     next_video_input_clocking = io_req.wdata;
            ECR_IDX_CONNSYNC:   next_connector_and_sync_control = io_req.wdata;
            ECR_IDX_MCLK_LOW: begin
               next_memclk_divider_low = io_req.wdata;
               next_load_mem = load_now;
            end
            ECR_IDX_MCLK_HIGH: begin
               next_memclk_divider_high = io_req.wdata;
               next_load_mem = load_now;
            end
            ECR_IDX_DOT_CLOCK_LOW: begin
               next_dotclk_divider_low = io_req.wdata;
               next_load_dot = load_now;
            end
            ECR_IDX_DOT_CLOCK_HIGH: begin
               next_dotclk_divider_high = io_req.wdata;
               next_load_dot = load_now;
            end
            ECR_IDX_SYNTH_LOAD: begin
               next_synth_load_control = io_req.wdata;
               next_load_mem = io_req.wdata[ECR_BIT_LOAD_MCLK]
                             | io_req.wdata[ECR_BIT_LOAD_NOW];
               next_load_dot = io_req.wdata[ECR_BIT_LOAD_DOT_CLOCK]
                             | io_req.wdata[ECR_BIT_LOAD_NOW];
            end
            default: begin
            end
         endcase
      end
   end

   // Reads answer one cycle later; ignored port reads give no answer
   // A read beside a write in one cycle sees the byte before the write
   always_comb begin
      next_io_rvalid = 1'b0;
      next_io_rdata  = io_rdata;
      if (access_ok && io_req.read) begin
         next_io_rvalid = 1'b1;
         next_io_rdata  = io_req.data_port ? read_byte : index;
      end
   end

   // Answer registers; data holds until the next answered read
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata  <= ECR_RESET_BYTE;
         io_rvalid <= 1'b0;
      end else begin
         io_rdata  <= next_io_rdata;
         io_rvalid <= next_io_rvalid;
      end
   end

   // Unlock status flag follows the key, as a readable level
   // Software sees the key a cycle late; write gating uses it live
   always_comb begin
      next_unlocked_q = key_ok;
   end

   // Status flag register; reset shows the bank as locked
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         unlocked_q <= 1'b0;
      end else begin
         unlocked_q <= next_unlocked_q;
      end
   end

   // Everything resets to zero, which leaves the bank locked
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         index                      <= ECR_RESET_BYTE;
         bank_unlock                <= ECR_RESET_BYTE;
         access_mode_select         <= ECR_RESET_BYTE;
         memory_bus_options         <= ECR_RESET_BYTE;
         video_input_clocking       <= ECR_RESET_BYTE;
         connector_and_sync_control <= ECR_RESET_BYTE;
         memclk_divider_low         <= ECR_RESET_BYTE;
         memclk_divider_high        <= ECR_RESET_BYTE;
         dotclk_divider_low         <= ECR_RESET_BYTE;
         dotclk_divider_high        <= ECR_RESET_BYTE;
         synth_load_control         <= ECR_RESET_BYTE;
      end else begin
         index                      <= next_index;
         bank_unlock                <= next_bank_unlock;
         access_mode_select         <= next_access_mode_select;
         memory_bus_options         <= next_memory_bus_options;
         video_input_clocking       <= next_video_input_clocking;
         connector_and_sync_control <= next_connector_and_sync_control;
         memclk_divider_low         <= next_memclk_divider_low;
         memclk_divider_high        <= next_memclk_divider_high;
         dotclk_divider_low         <= next_dotclk_divider_low;
         dotclk_divider_high        <= next_dotclk_divider_high;
         synth_load_control         <= next_synth_load_control;
      end
   end

   // Load strobes last one cycle; stored load bits never self-clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         load_mem <= 1'b0;
         load_dot <= 1'b0;
      end else begin
         load_mem <= next_load_mem;
         load_dot <= next_load_dot;
      end
   end

   // Control outputs other than bank_unlocked and the two active divider sets are plain slices of stored bytes
   assign bank_unlocked            = unlocked_q;
   assign mmio_only                = access_mode_select[ECR_BIT_MMIO_ONLY];
   assign pixel_bus_drive          =
      memory_bus_options[ECR_BIT_PIX_DRIVE];
   assign second_row_strobe_en     =
      memory_bus_options[ECR_BIT_SECOND_RAS];
   assign mem_write_two_clocks     =
      memory_bus_options[ECR_BIT_TWO_MCLK_WR];
   assign dot_clock_from_ext       =
      video_input_clocking[ECR_BIT_DOT_EXT];
   assign capture_on_ext_clock     =
      video_input_clocking[ECR_BIT_CAPT_EXT];
   assign feature_color_mode       =
      video_input_clocking[ECR_COLOR_MSB:ECR_COLOR_LSB];
   assign feature_enable           =
      connector_and_sync_control[ECR_BIT_FC_ENABLE];
   assign local_peripheral_bus_sel =
      connector_and_sync_control[ECR_BIT_FC_LOCAL];
   assign hsync_control            =
      connector_and_sync_control[ECR_HSYNC_MSB:ECR_HSYNC_LSB];
   assign vsync_control            =
      connector_and_sync_control[ECR_VSYNC_MSB:ECR_VSYNC_LSB];

   // Load is one cycle behind the write so the programmed byte has settled
   ecr_synth_latch u_memclk (
      .clock      (clock),
      .reset_n    (reset_n),
      .programmed (memclk_programmed),
      .load       (load_mem),
      .active     (memclk_active)
   );

   ecr_synth_latch u_dotclk (
      .clock      (clock),
      .reset_n    (reset_n),
      .programmed (dotclk_programmed),
      .load       (load_dot),
      .active     (dotclk_active)
   );

endmodule

`default_nettype wire

// *** dv/ecr_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module ecr_regs_assertions
   import ecr_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire ecr_io_req_s io_req,
   input wire logic [7:0]  io_rdata,
   input wire logic        io_rvalid,
   input wire logic        bank_unlocked,
   input wire logic        mmio_only,
   input wire logic        pixel_bus_drive,
   input wire logic [3:0]  feature_color_mode,
   input wire logic [1:0]  hsync_control,
   input wire logic [1:0]  vsync_control,
   input wire ecr_synth_s  memclk_active,
   input wire ecr_synth_s  dotclk_active
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Port I/O reads are not taken while memory-mapped only is set
   wire logic       taken_rd = io_req.read & ~(mmio_only & ~io_req.mmio);
   wire logic       dwr      = io_req.write & io_req.data_port;
   wire logic [9:0] cfg      = {mmio_only, pixel_bus_drive, feature_color_mode,
                                hsync_control, vsync_control};

   AST_READ_ANSWER: assert property (taken_rd |=> io_rvalid)
      else $error("read not answered next cycle");
   AST_NO_STRAY_ANSWER: assert property
      (io_rvalid |-> $past(taken_rd))
      else $error("answer without a taken read");
   AST_RDATA_HOLDS: assert property (!io_rvalid |-> $stable(io_rdata))
      else $error("read data moved without an answer");
   AST_PIO_IGNORED: assert property
      (mmio_only && !io_req.mmio && io_req.write |=> $stable(cfg))
      else $error("port write acted under memory-mapped only");
   AST_CFG_CAUSE: assert property ($changed(cfg) |-> $past(dwr))
      else $error("config changed without a data write");
   AST_MCLK_LOAD: assert property
      ($changed(memclk_active) |-> $past(dwr, 2) || $past(dwr, 3))
      else $error("memory clock dividers moved without a load");
   AST_DOT_CLOCK_LOAD: assert property
      ($changed(dotclk_active) |-> $past(dwr, 2) || $past(dwr, 3))
      else $error("dot clock dividers moved without a load");
   AST_UNLOCK_CAUSE: assert property
      ($changed(bank_unlocked) |-> $past(dwr, 2))
      else $error("unlock flag moved without a write");
   AST_LOCKED_AT_START: assert property ($rose(reset_n) |->
      !bank_unlocked && memclk_active == ECR_RESET_SYNTH)
      else $error("bank not locked after reset");
endmodule

bind ecr_regs ecr_regs_assertions u_chk (.clock, .reset_n, .io_req,
   .io_rdata, .io_rvalid, .bank_unlocked, .mmio_only, .pixel_bus_drive,
   .feature_color_mode, .hsync_control, .vsync_control, .memclk_active,
   .dotclk_active);

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb
   import ecr_pkg::*;
;
   logic        clock, reset_n, io_rvalid, bank_unlocked, mmio_only;
   logic        pixel_bus_drive, second_row_strobe_en, mem_write_two_clocks;
   logic        dot_clock_from_ext, capture_on_ext_clock, feature_enable;
   logic        local_peripheral_bus_sel;
   logic [7:0]  io_rdata;
   logic [3:0]  feature_color_mode;
   logic [1:0]  hsync_control, vsync_control;
   ecr_synth_s  memclk_active, dotclk_active;
   ecr_io_req_s io_req;
   int          fails, checked;
   logic [7:0]  ix [7] = '{8'h0a, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13};
   logic [7:0]  va [7] = '{8'ha0, 8'h51, 8'h9d, 8'he3, 8'hd5, 8'h2a, 8'h7f};
   logic [7:0]  vb [7] = '{8'h5f, 8'ha2, 8'h62, 8'h9c, 8'h2a, 8'hd5, 8'h80};

   ecr_regs dut (.clock, .reset_n, .io_req, .io_rdata, .io_rvalid,
      .bank_unlocked, .mmio_only, .pixel_bus_drive, .second_row_strobe_en,
      .mem_write_two_clocks, .dot_clock_from_ext, .capture_on_ext_clock,
      .feature_color_mode, .feature_enable, .local_peripheral_bus_sel,
      .hsync_control, .vsync_control, .memclk_active, .dotclk_active);

   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic give_verdict();
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask

   // One request per cycle, launched just after the edge
   task automatic issue(input logic w, r, p, m, input logic [7:0] d);
      io_req = '{write: w, read: r, data_port: p, mmio: m, wdata: d};
      @(posedge clock);
      #1;
   endtask

   // Two idle cycles let divider loads and the unlock flag settle
   task automatic wr(input logic [7:0] idx, d, input logic m = 1'b1);
      issue(1'b1, 1'b0, 1'b0, m, idx);
      issue(1'b1, 1'b0, 1'b1, m, d);
      issue(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      issue(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
   endtask

   task automatic rd(input string n, input logic [7:0] idx, e,
                     input logic m = 1'b1, ev = 1'b1);
      issue(1'b1, 1'b0, 1'b0, m, idx);
      issue(1'b0, 1'b1, 1'b1, m, 8'h00);
      cmp(n, {io_rvalid, io_rdata}, {ev, e});
   endtask

   task automatic outs(input logic [7:0] a, b, d);
      cmp("drive", pixel_bus_drive, a[5]);
      cmp("ras2", second_row_strobe_en, a[6]);
      cmp("wr2", mem_write_two_clocks, a[7]);
      cmp("dotext", dot_clock_from_ext, b[0]);
      cmp("capt", capture_on_ext_clock, b[1]);
      cmp("color", feature_color_mode, b[7:4]);
      cmp("fc_en", feature_enable, d[0]);
      cmp("fc_local", local_peripheral_bus_sel, d[1]);
      cmp("hs", hsync_control, d[5:4]);
      cmp("vs", vsync_control, d[7:6]);
   endtask

   // Write a whole set, then read it back; reserved bits must survive
   task automatic load_set(input logic [7:0] v [7]);
      for (int i = 0; i < 7; i++) wr(ix[i], v[i]);
      for (int i = 0; i < 7; i++) rd("readback", ix[i], v[i]);
      outs(v[0], v[1], v[2]);
   endtask

   // Watchdog, well beyond the roughly 150 cycles the tests need
   initial begin
      repeat (4000) @(posedge clock);
      fails++;
      give_verdict();
   end

   // Main sequence
   initial begin
      reset_n = 1'b0;
      io_req = '0;
      fails = 0;
      checked = 0;
      repeat (2) @(posedge clock);
      #1;
      reset_n = 1'b1;
      outs(8'h00, 8'h00, 8'h00);
      cmp("unl0", bank_unlocked, 1'b0);
      cmp("mclk0", memclk_active, 16'h0000);
      wr(8'h0a, 8'hff);
      rd("locked", 8'h0a, 8'h00);
      wr(8'h08, 8'hf6);
      cmp("unl1", bank_unlocked, 1'b1);
      rd("key", 8'h08, 8'hf6);
      load_set(va);
      cmp("mclk_wait", memclk_active, 16'h0000);
      wr(8'h15, 8'h01);
      cmp("mclk_a", memclk_active, {va[4][6:0], va[3][6:0]});
      cmp("dot_clock_wait", dotclk_active, 16'h0000);
      wr(8'h15, 8'h02);
      cmp("dot_clock_a", dotclk_active, {va[6][6:0], va[5][6:0]});
      load_set(vb);
      cmp("mclk_hold", memclk_active, {va[4][6:0], va[3][6:0]});
      cmp("dot_clock_hold", dotclk_active, {va[6][6:0], va[5][6:0]});
      wr(8'h15, 8'h20);
      cmp("mclk_b", memclk_active, {vb[4][6:0], vb[3][6:0]});
      cmp("dot_clock_b", dotclk_active, {vb[6][6:0], vb[5][6:0]});
      wr(8'h10, 8'h05);
      cmp("mclk_now", memclk_active, {vb[4][6:0], 7'h05});
      wr(8'h09, 8'h80, 1'b0);
      cmp("mmio", mmio_only, 1'b1);
      wr(8'h0a, 8'h00, 1'b0);
      rd("pio_rd", 8'h0a, vb[6], 1'b0, 1'b0);
      outs(vb[0], vb[1], vb[2]);
      rd("mmio_rd", 8'h0a, vb[0]);
      wr(8'h09, 8'h00);
      cmp("mmio_off", mmio_only, 1'b0);
      wr(8'h08, 8'ha5);
      cmp("relock", bank_unlocked, 1'b0);
      wr(8'h0b, 8'h00);
      rd("dropped", 8'h0b, vb[1]);
      wr(8'h08, 8'h06);
      wr(8'h0c, 8'hff);
      rd("unmapped", 8'h0c, 8'h00);
      issue(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
      cmp("idx_rd", {io_rvalid, io_rdata}, {1'b1, 8'h0c});
      give_verdict();
   end
endmodule

`default_nettype wire
